// ==== rtl/rch_handler.v ====
// reconfiguration action message handler, downstream side
`timescale 1ns/1ps
`include "rch_defs.vh"

module rch_handler (
  input wire REF_CLK,
  input wire RST_N,
  input wire MSG_VALID,
  input wire [1:0] MSG_KIND,
  input wire [`RCH_NAME_W-1:0] MSG_NAME,
  input wire [`RCH_NLEN_W-1:0] MSG_NAME_LEN,
  input wire [`RCH_UTC_W-1:0] MSG_UTC,
  input wire [`RCH_DFCT_W-1:0] MSG_DFCT,
  input wire NAME_KNOWN,
  input wire RES_AVAIL,
  input wire INST_OK,
  input wire CAN_TOO_LATE,
  input wire IMPOSE_VALID,
  input wire [`RCH_NAME_W-1:0] IMPOSE_NAME,
  input wire [`RCH_UTC_W-1:0] IMPOSE_UTC,
  input wire [`RCH_DFCT_W-1:0] IMPOSE_DFCT,
  input wire RECONF_DONE,
  output reg RPL_VALID,
  output reg [1:0] RPL_KIND,
  output reg [`RCH_NAME_W-1:0] RPL_NAME,
  output reg [`RCH_UTC_W-1:0] RPL_UTC,
  output reg [`RCH_DFCT_W-1:0] RPL_DFCT,
  output reg [31:0] RPL_CAUSE,
  output reg PENDING,
  output reg [`RCH_NAME_W-1:0] PEND_NAME,
  output reg [`RCH_UTC_W-1:0] PEND_UTC,
  output reg [`RCH_DFCT_W-1:0] PEND_DFCT
);

// ---------------------------------------------------------------
// field checks
// ---------------------------------------------------------------
function is_digit;
  input [7:0] c;
  input [7:0] hi;
  begin
    is_digit = (c >= `RCH_CH_0) && (c <= hi);
  end
endfunction

// characters are held first-in-top; index 7 is the first utc character
wire [7:0] u [0:7];
wire [7:0] f [0:5];
genvar gi;
generate
  for (gi = 0; gi < 8; gi = gi + 1) begin : g_utc
    assign u[gi] = MSG_UTC[8*gi+7:8*gi];
  end
  for (gi = 0; gi < 6; gi = gi + 1) begin : g_dfct
    assign f[gi] = MSG_DFCT[8*gi+7:8*gi];
  end
endgenerate

// hours 00..23: a leading 2 limits the second digit to 3
wire hh_ok = (is_digit(u[7], `RCH_CH_1) && is_digit(u[6], `RCH_CH_9)) ||
  ((u[7] == `RCH_CH_2) && is_digit(u[6], `RCH_CH_3));
wire mm_ok = is_digit(u[4], `RCH_CH_5) && is_digit(u[3], `RCH_CH_9);
wire ss_ok = is_digit(u[1], `RCH_CH_5) && is_digit(u[0], `RCH_CH_9);
wire utc_ok = hh_ok && mm_ok && ss_ok && (u[5] == `RCH_CH_COLON) &&
  (u[2] == `RCH_CH_COLON);

// upper 00..19
wire uu_ok = is_digit(f[5], `RCH_CH_1) && is_digit(f[4], `RCH_CH_9);
// lower 000..249: 0xx/1xx free, 2xx limits tens to 4
wire lll_ok = (is_digit(f[2], `RCH_CH_1) && is_digit(f[1], `RCH_CH_9) &&
  is_digit(f[0], `RCH_CH_9)) || ((f[2] == `RCH_CH_2) &&
  is_digit(f[1], `RCH_CH_4) && is_digit(f[0], `RCH_CH_9));
wire dfct_ok = uu_ok && lll_ok && (f[3] == `RCH_CH_COLON);

// reserved monitoring names are treated as unknown configurations
wire name_rsv = ((MSG_NAME == `RCH_RSV_CURRENT) &&
  (MSG_NAME_LEN == `RCH_LEN_CURRENT)) ||
  ((MSG_NAME == `RCH_RSV_NEXT) && (MSG_NAME_LEN == `RCH_LEN_NEXT));
wire name_len_ok = (MSG_NAME_LEN >= `RCH_LEN_MIN) &&
  (MSG_NAME_LEN <= `RCH_LEN_MAX);
wire name_ok = NAME_KNOWN && !name_rsv && name_len_ok;

// ---------------------------------------------------------------
// message decision
// ---------------------------------------------------------------
reg rpl_valid_nxt;
reg [1:0] rpl_kind_nxt;
reg [`RCH_NAME_W-1:0] rpl_name_nxt;
reg [`RCH_UTC_W-1:0] rpl_utc_nxt;
reg [`RCH_DFCT_W-1:0] rpl_dfct_nxt;
reg [31:0] rpl_cause_nxt;
reg pending_nxt;
reg [`RCH_NAME_W-1:0] pend_name_nxt;
reg [`RCH_UTC_W-1:0] pend_utc_nxt;
reg [`RCH_DFCT_W-1:0] pend_dfct_nxt;

always @* begin
  rpl_valid_nxt = 1'b0;
  rpl_kind_nxt = RPL_KIND;
  rpl_name_nxt = RPL_NAME;
  rpl_utc_nxt = RPL_UTC;
  rpl_dfct_nxt = RPL_DFCT;
  rpl_cause_nxt = RPL_CAUSE;
  pending_nxt = PENDING;
  pend_name_nxt = PEND_NAME;
  pend_utc_nxt = PEND_UTC;
  pend_dfct_nxt = PEND_DFCT;
  // the procedure ran at its instant; nothing left to hold
  if (RECONF_DONE) begin
    pending_nxt = 1'b0;
  end
  if (MSG_VALID) begin
    rpl_valid_nxt = 1'b1;
    case (MSG_KIND)
      `RCH_MSG_REQ: begin
        rpl_kind_nxt = `RCH_RPL_ERR;
        // busy is checked first so a second request never disturbs the
        // one already held
        if (PENDING && !RECONF_DONE) begin
          rpl_cause_nxt = `RCH_CAUSE_PEND;
        end else if (!name_ok) begin
          rpl_cause_nxt = `RCH_CAUSE_NAME;
        end else if (!utc_ok || !dfct_ok || !INST_OK) begin
          rpl_cause_nxt = `RCH_CAUSE_INST;
        end else if (!RES_AVAIL) begin
          rpl_cause_nxt = `RCH_CAUSE_NRES;
        end else begin
          rpl_kind_nxt = `RCH_RPL_DEF;
          rpl_name_nxt = MSG_NAME;
          rpl_utc_nxt = MSG_UTC;
          rpl_dfct_nxt = MSG_DFCT;
          pending_nxt = 1'b1;
          pend_name_nxt = MSG_NAME;
          pend_utc_nxt = MSG_UTC;
          pend_dfct_nxt = MSG_DFCT;
        end
      end
      `RCH_MSG_INF: begin
        if (PENDING && !RECONF_DONE) begin
          rpl_kind_nxt = `RCH_RPL_DEF;
          rpl_name_nxt = PEND_NAME;
          rpl_utc_nxt = PEND_UTC;
          rpl_dfct_nxt = PEND_DFCT;
        end else begin
          rpl_kind_nxt = `RCH_RPL_ERR;
          rpl_cause_nxt = `RCH_CAUSE_NONE;
        end
      end
      `RCH_MSG_CAN: begin
        rpl_kind_nxt = `RCH_RPL_ERR;
        if (!PENDING || RECONF_DONE) begin
          rpl_cause_nxt = `RCH_CAUSE_NONE;
        end else if (CAN_TOO_LATE) begin
          rpl_cause_nxt = `RCH_CAUSE_LATE;
        end else begin
          // cancel and acknowledge land on the same edge
          rpl_kind_nxt = `RCH_RPL_ACK;
          pending_nxt = 1'b0;
        end
      end
      default: begin
        rpl_valid_nxt = 1'b0;
      end
    endcase
  end else if (IMPOSE_VALID && !(PENDING && !RECONF_DONE)) begin
    // imposed definition; upstream has no way to refuse it
    rpl_valid_nxt = 1'b1;
    rpl_kind_nxt = `RCH_RPL_DEF;
    rpl_name_nxt = IMPOSE_NAME;
    rpl_utc_nxt = IMPOSE_UTC;
    rpl_dfct_nxt = IMPOSE_DFCT;
    pending_nxt = 1'b1;
    pend_name_nxt = IMPOSE_NAME;
    pend_utc_nxt = IMPOSE_UTC;
    pend_dfct_nxt = IMPOSE_DFCT;
  end
end

// ---------------------------------------------------------------
// state and outputs
// ---------------------------------------------------------------
always @(posedge REF_CLK or negedge RST_N) begin
  if (!RST_N) begin
    RPL_VALID <= 1'b0;
    RPL_KIND <= `RCH_RPL_DEF;
    RPL_NAME <= {`RCH_NAME_W{1'b0}};
    RPL_UTC <= {`RCH_UTC_W{1'b0}};
    RPL_DFCT <= {`RCH_DFCT_W{1'b0}};
    RPL_CAUSE <= 32'h00000000;
    PENDING <= 1'b0;
    PEND_NAME <= {`RCH_NAME_W{1'b0}};
    PEND_UTC <= {`RCH_UTC_W{1'b0}};
    PEND_DFCT <= {`RCH_DFCT_W{1'b0}};
  end else begin
    RPL_VALID <= rpl_valid_nxt;
    RPL_KIND <= rpl_kind_nxt;
    RPL_NAME <= rpl_name_nxt;
    RPL_UTC <= rpl_utc_nxt;
    RPL_DFCT <= rpl_dfct_nxt;
    RPL_CAUSE <= rpl_cause_nxt;
    PENDING <= pending_nxt;
    PEND_NAME <= pend_name_nxt;
    PEND_UTC <= pend_utc_nxt;
    PEND_DFCT <= pend_dfct_nxt;
  end
end

endmodule // rch_handler

// ==== rtl/rch_defs.vh ====
// constants for the reconfiguration action handler
`ifndef RCH_DEFS_VH
`define RCH_DEFS_VH

// upstream message codes on the request port
`define RCH_MSG_REQ 2'h0
`define RCH_MSG_INF 2'h1
`define RCH_MSG_CAN 2'h2

// reply kinds on the reply port
`define RCH_RPL_DEF 2'h0
`define RCH_RPL_ACK 2'h1
`define RCH_RPL_ERR 2'h2

// four-character cause codes, ascii, first character in the top byte
`define RCH_CAUSE_NONE 32'h4e4f4e45
`define RCH_CAUSE_NAME 32'h4e414d45
`define RCH_CAUSE_INST 32'h494e5354
`define RCH_CAUSE_PEND 32'h50454e44
`define RCH_CAUSE_NRES 32'h4e524553
`define RCH_CAUSE_LATE 32'h4c415445

// field widths in bits: name 16 chars, utc 8 chars, frame count 6 chars
`define RCH_NAME_W 128
`define RCH_UTC_W 64
`define RCH_DFCT_W 48
`define RCH_NLEN_W 5

// ascii characters used in the field checks
`define RCH_CH_0 8'h30
`define RCH_CH_1 8'h31
`define RCH_CH_2 8'h32
`define RCH_CH_3 8'h33
`define RCH_CH_4 8'h34
`define RCH_CH_5 8'h35
`define RCH_CH_9 8'h39
`define RCH_CH_COLON 8'h3a

// reserved names, left aligned and zero padded to 16 characters
`define RCH_RSV_CURRENT 128'h43555252454e54000000000000000000
`define RCH_RSV_NEXT 128'h4e455854000000000000000000000000
`define RCH_LEN_CURRENT 5'h07
`define RCH_LEN_NEXT 5'h04
`define RCH_LEN_MAX 5'h10
`define RCH_LEN_MIN 5'h01

`endif

// ==== dv/rch_up_model.sv ====
// upstream entity model: issues request, query and cancel messages
`timescale 1ns/1ps
`include "rch_defs.vh"
module rch_up_model (
  input wire clk,
  output reg valid,
  output reg [1:0] kind,
  output reg [`RCH_NAME_W-1:0] name,
  output reg [`RCH_NLEN_W-1:0] len,
  output reg [`RCH_UTC_W-1:0] utc,
  output reg [`RCH_DFCT_W-1:0] dfct
);
  initial begin
    {valid, kind, name, len, utc, dfct} = '0;
  end
  // only this side issues requests, queries and cancels
  // the bench reads each reply 1 ns after the edge that samples the message and registers the reply
  task send(input [1:0] k, input [127:0] n, input [4:0] l,
            input [63:0] u, input [47:0] d);
    @(posedge clk);
    #1;
    {valid, kind, name, len, utc, dfct} = {1'b1, k, n, l, u, d};
    @(posedge clk);
    #1;
    valid = 1'b0;
    // released fields turn over so stale values are never read as good
    {kind, name, len, utc, dfct} = ~{kind, name, len, utc, dfct};
  endtask
endmodule // rch_up_model

// ==== dv/rch_handler_properties.sv ====
// port checker for the reconfiguration handler
`timescale 1ns/1ps
`include "rch_defs.vh"
module rch_chk (
  input wire REF_CLK,
  input wire RST_N,
  input wire MSG_VALID,
  input wire [1:0] MSG_KIND,
  input wire CAN_TOO_LATE,
  input wire IMPOSE_VALID,
  input wire RECONF_DONE,
  input wire RPL_VALID,
  input wire [1:0] RPL_KIND,
  input wire [31:0] RPL_CAUSE,
  input wire PENDING
);
  // a done pulse frees the slot for a message in the same cycle
  wire busy = PENDING && !RECONF_DONE;
  wire can = MSG_VALID && MSG_KIND == `RCH_MSG_CAN;
  wire inf = MSG_VALID && MSG_KIND == `RCH_MSG_INF;
  wire req = MSG_VALID && MSG_KIND == `RCH_MSG_REQ;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  reply_lat_a: assert property ((can || inf || req) |=> RPL_VALID)
    else $error("reply missing");
  no_reply_a: assert property (MSG_VALID && &MSG_KIND |=> !RPL_VALID)
    else $error("reply to unknown kind");
  pend_rise_a: assert property ($rose(PENDING) |->
    RPL_VALID && RPL_KIND == `RCH_RPL_DEF) else $error("pending without def");
  one_pend_a: assert property (req && busy |=>
    RPL_CAUSE == `RCH_CAUSE_PEND) else $error("busy request not refused");
  inf_none_a: assert property (inf && !busy |=>
    RPL_KIND == `RCH_RPL_ERR && RPL_CAUSE == `RCH_CAUSE_NONE)
    else $error("idle query not refused");
  can_ack_a: assert property (can && busy && !CAN_TOO_LATE |=>
    RPL_KIND == `RCH_RPL_ACK && !PENDING) else $error("cancel not acked");
  can_late_a: assert property (can && busy && CAN_TOO_LATE |=>
    RPL_CAUSE == `RCH_CAUSE_LATE && PENDING) else $error("late cancel taken");
  done_clr_a: assert property (RECONF_DONE && !(MSG_VALID || IMPOSE_VALID) |=>
    !PENDING) else $error("pending after done");
endmodule // rch_chk
bind rch_handler rch_chk chk_u (.REF_CLK(REF_CLK), .RST_N(RST_N),
  .MSG_VALID(MSG_VALID), .MSG_KIND(MSG_KIND), .CAN_TOO_LATE(CAN_TOO_LATE),
  .IMPOSE_VALID(IMPOSE_VALID), .RECONF_DONE(RECONF_DONE),
  .RPL_VALID(RPL_VALID), .RPL_KIND(RPL_KIND), .RPL_CAUSE(RPL_CAUSE),
  .PENDING(PENDING));

// ==== dv/rch_handler_tb.sv ====
// self-checking bench for the reconfiguration handler
`timescale 1ns/1ps
`include "rch_defs.vh"
module rch_handler_tb;
  reg REF_CLK = 1'b0;
  reg RST_N = 1'b0;
  reg NAME_KNOWN = 1'b1;
  reg RES_AVAIL = 1'b1;
  reg INST_OK = 1'b1;
  reg CAN_TOO_LATE = 1'b0;
  reg IMPOSE_VALID = 1'b0;
  reg RECONF_DONE = 1'b0;
  wire MSG_VALID, RPL_VALID, PENDING;
  wire [1:0] MSG_KIND, RPL_KIND;
  wire [127:0] MSG_NAME, RPL_NAME, PEND_NAME;
  wire [4:0] MSG_NAME_LEN;
  wire [63:0] MSG_UTC, RPL_UTC, PEND_UTC;
  wire [47:0] MSG_DFCT, RPL_DFCT, PEND_DFCT;
  wire [31:0] RPL_CAUSE;
  reg [127:0] nm = 128'h0;
  reg [4:0] ln = 5'h04;
  reg [63:0] ut = 64'h0;
  reg [47:0] df = 48'h0;
  integer n_fail = 0, n_compared = 0, cyc = 0, i;
  rch_up_model up_u (.clk(REF_CLK), .valid(MSG_VALID), .kind(MSG_KIND),
    .name(MSG_NAME), .len(MSG_NAME_LEN), .utc(MSG_UTC), .dfct(MSG_DFCT));
  rch_handler dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .MSG_VALID(MSG_VALID), .MSG_KIND(MSG_KIND), .MSG_NAME(MSG_NAME),
    .MSG_NAME_LEN(MSG_NAME_LEN), .MSG_UTC(MSG_UTC), .MSG_DFCT(MSG_DFCT),
    .NAME_KNOWN(NAME_KNOWN), .RES_AVAIL(RES_AVAIL), .INST_OK(INST_OK),
    .CAN_TOO_LATE(CAN_TOO_LATE), .IMPOSE_VALID(IMPOSE_VALID),
    .IMPOSE_NAME(nm), .IMPOSE_UTC(ut), .IMPOSE_DFCT(df),
    .RECONF_DONE(RECONF_DONE), .RPL_VALID(RPL_VALID), .RPL_KIND(RPL_KIND),
    .RPL_NAME(RPL_NAME), .RPL_UTC(RPL_UTC), .RPL_DFCT(RPL_DFCT),
    .RPL_CAUSE(RPL_CAUSE), .PENDING(PENDING), .PEND_NAME(PEND_NAME),
    .PEND_UTC(PEND_UTC), .PEND_DFCT(PEND_DFCT));
  initial begin
    forever #20 REF_CLK = ~REF_CLK;
  end
  // two ascii digits of a value below 100
  function [15:0] d2(input integer v);
    d2 = 16'(16'h3030 + (v / 10) * 256 + v % 10);
  endfunction
  function [63:0] utc(input integer h, input integer m, input integer s);
    utc = {d2(h), 8'h3a, d2(m), 8'h3a, d2(s)};
  endfunction
  function [47:0] dfct(input integer u, input integer l);
    dfct = {d2(u), 8'h3a, 8'h30 + 8'(l / 100), d2(l % 100)};
  endfunction
  task chk(input [127:0] seen, input [127:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task msg(input [1:0] k, input [1:0] ek, input [31:0] ec);
    up_u.send(k, nm, ln, ut, df);
    chk(RPL_VALID, 1'b1);
    chk(RPL_KIND, ek);
    if (ek == `RCH_RPL_ERR) chk(RPL_CAUSE, ec);
  endtask
  task pulse(input imp);
    @(posedge REF_CLK);
    #1;
    {IMPOSE_VALID, RECONF_DONE} = {imp, !imp};
    @(posedge REF_CLK);
    #1;
    {IMPOSE_VALID, RECONF_DONE} = 2'h0;
  endtask
  task stop_test;
    $display("compared %0d, wrong %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang counts as a failure
  always @(posedge REF_CLK) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      stop_test;
    end
  end
  initial begin
    i = $urandom(32'h4a841f83);
    repeat (16) @(posedge REF_CLK);
    #1 RST_N = 1'b1;
    msg(`RCH_MSG_INF, `RCH_RPL_ERR, `RCH_CAUSE_NONE);
    msg(`RCH_MSG_CAN, `RCH_RPL_ERR, `RCH_CAUSE_NONE);
    up_u.send(2'h3, nm, ln, ut, df);
    chk(RPL_VALID, 1'b0);
    $display("test idle done");
    for (i = 0; i < 7; i = i + 1) begin
      nm = {"CFG", 8'h30 + 8'($urandom % 10), 96'h0};
      ut = i ? utc($urandom % 24, $urandom % 60, $urandom % 60) : utc(23, 59, 59);
      df = i ? dfct($urandom % 20, $urandom % 250) : dfct(19, 249);
      msg(`RCH_MSG_REQ, `RCH_RPL_DEF, 0);
      chk({PENDING, RPL_UTC, RPL_DFCT}, {1'b1, ut, df});
      chk({PEND_NAME, PEND_UTC, PEND_DFCT}, {nm, ut, df});
      msg(`RCH_MSG_REQ, `RCH_RPL_ERR, `RCH_CAUSE_PEND);
      msg(`RCH_MSG_INF, `RCH_RPL_DEF, 0);
      chk(RPL_NAME, nm);
      CAN_TOO_LATE = 1'b1;
      msg(`RCH_MSG_CAN, `RCH_RPL_ERR, `RCH_CAUSE_LATE);
      CAN_TOO_LATE = 1'b0;
      msg(`RCH_MSG_CAN, `RCH_RPL_ACK, 0);
      chk(PENDING, 1'b0);
    end
    $display("test request cycle done");
    for (i = 0; i < 7; i = i + 1) begin
      {NAME_KNOWN, RES_AVAIL, INST_OK} = {i != 0, i != 1, i != 2};
      nm = (i == 3) ? `RCH_RSV_CURRENT : (i == 6) ? `RCH_RSV_NEXT :
        {"CFG1", 96'h0};
      ln = (i == 3) ? `RCH_LEN_CURRENT : (i == 6) ? `RCH_LEN_NEXT : 5'h04;
      ut = utc((i == 4) ? 24 : 12, 0, 0);
      df = dfct(0, (i == 5) ? 250 : 0);
      msg(`RCH_MSG_REQ, `RCH_RPL_ERR, (i == 1) ? `RCH_CAUSE_NRES :
        (i == 0 || i == 3 || i == 6) ? `RCH_CAUSE_NAME :
        `RCH_CAUSE_INST);
    end
    {NAME_KNOWN, RES_AVAIL, INST_OK} = 3'h7;
    $display("test refusals done");
    pulse(1'b1);
    chk({RPL_VALID, RPL_KIND, PENDING}, {1'b1, `RCH_RPL_DEF, 1'b1});
    chk(PEND_NAME, nm);
    pulse(1'b0);
    chk(PENDING, 1'b0);
    $display("test impose done");
    stop_test;
  end
endmodule // rch_handler_tb
